// ### logic/mspr_pkg.sv
// Package with register map, field positions and carrier types for the PCS status bank
package mspr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices and byte addresses
    localparam logic [7:0]  IDX_PCS_CONTROL  = 8'h10;
    localparam logic [7:0]  IDX_PCS_STATUS   = 8'h11;
    localparam logic [7:0]  IDX_ADV_WORD     = 8'h12;
    localparam logic [7:0]  IDX_PARTNER_WORD = 8'h13;
    localparam logic [7:0]  IDX_COMMA_STATUS = 8'h14;
    localparam logic [7:0]  IDX_TX_GOOD      = 8'h15;
    localparam logic [7:0]  IDX_TX_SELECT    = 8'h16;
    localparam logic [11:0] ADDR_PCS_CONTROL  = {2'h0, IDX_PCS_CONTROL, 2'h0};
    localparam logic [11:0] ADDR_PCS_STATUS   = {2'h0, IDX_PCS_STATUS, 2'h0};
    localparam logic [11:0] ADDR_ADV_WORD     = {2'h0, IDX_ADV_WORD, 2'h0};
    localparam logic [11:0] ADDR_PARTNER_WORD = {2'h0, IDX_PARTNER_WORD, 2'h0};
    localparam logic [11:0] ADDR_COMMA_STATUS = {2'h0, IDX_COMMA_STATUS, 2'h0};
    localparam logic [11:0] ADDR_TX_GOOD      = {2'h0, IDX_TX_GOOD, 2'h0};
    localparam logic [11:0] ADDR_TX_SELECT    = {2'h0, IDX_TX_SELECT, 2'h0};

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_FORCE_ADV     = 11;
    localparam int BIT_SYNC_LOST     = 15;
    localparam int BIT_CG_BAD        = 14;
    localparam int BIT_ALIGN_ERR     = 12;
    localparam int BIT_LP_RESTART    = 11;
    localparam int BIT_CNT_ACTIVE    = 15;
    localparam int SEL_LSB           = 14;
    localparam logic [1:0] SEL_MEDIA = 2'h0;
    localparam logic [1:0] SEL_MAC   = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and counts
    localparam logic [15:0] RESET_CONTROL  = 16'h0000;
    localparam logic [15:0] RESET_ADV_WORD = 16'h0000;
    localparam logic [13:0] TX_COUNT_WRAP  = 14'h270F;

    ////////////////////////////////////////////////////////////////////////////
    // Live state reported by the PCS on the serial side
    typedef struct packed {
        logic        sync_lost;
        logic        cg_bad;
        logic        align_err;
        logic        lp_restart;
        logic [1:0]  remote_fault;
        logic [3:0]  lp_abilities;
        logic        lp_an_capable;
        logic        link_up;
        logic        an_complete;
        logic        signal_detect;
    } mspr_pcs_type;

    // Comma and word events from the receiver
    typedef struct packed {
        logic        comma_realign;
        logic        serdes_sig_det;
        logic        qsgmii_sync;
        logic        comma_detect;
        logic [3:0]  comma_pos;
        logic        partner_word_valid;
        logic [15:0] partner_word;
    } mspr_rx_type;

    // Transmit packet events
    typedef struct packed {
        logic media_link_up;
        logic mac_tx_good;
        logic media_tx_good;
    } mspr_tx_type;

endpackage : mspr_pkg

// ### logic/mspr_regs.sv
// MAC SerDes PCS status and ability register bank behind an APB slave
// Overview of operation
// (RULE_01) Bit 15: sync lost since last read
// (RULE_02) Bit 14: bad code-group since last read
// (RULE_03) Bit 12: SGMII alignment error seen
// (RULE_04) Bit 11: partner asked autoneg restart
// (RULE_05) Bits 9:8: remote fault from MAC
// (RULE_06) Bits 7:4: MAC advertised pause/duplex abilities
// (RULE_07) Bit 3: partner autoneg capable
// (RULE_08) Bits 2:0: link, autoneg done, signal
// (RULE_09) Advertised word, reset zero, write when forced
// (RULE_10) Advertised read undefined when not forced
// (RULE_11) Hold last received partner code word
// (RULE_12) Comma realigned: sticky, clear on read
// (RULE_13) Signal detect event: sticky, clear on read
// (RULE_14) QSGMII sync status, first port only
// (RULE_15) Comma detect live, one after read
// (RULE_16) Bits 11:8: comma position 0..9
// (RULE_17) Bit 15: good counter active
// (RULE_18) Good packet count wraps modulo 10000
// (RULE_19) Force bit selects register advertised word
// (RULE_20) Select field: 00 media, 01 MAC
// (RULE_21) Counters advance only with media link
// (RULE_22) Reload since-read flags after status read
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module mspr_regs #(
    parameter bit FIRST_PORT = 1'b1
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire mspr_pkg::mspr_pcs_type pcs_in,
    input  wire mspr_pkg::mspr_rx_type  rx_in,
    input  wire mspr_pkg::mspr_tx_type  tx_in,
    input  wire logic [15:0]           internal_adv_word,
    output logic      [15:0]           adv_word_out,
    output logic                       force_advertised_ability_bit
);
    import mspr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Behaviour notes
    //
    // Bus timing
    // Setup: psel high, penable low
    // First access cycle takes the request
    // Second access cycle: pready pulse
    // One wait state on every transfer
    // Back-to-back transfers accepted
    // Write lands with the pready rise
    // Read data held until next read
    // Upper read half always zero
    // Byte lanes 0 and 1 act per byte
    // Byte lanes 2 and 3 ignored
    // Pslverr only with pready
    // Pready low during reset
    //
    // Errors
    // Unmapped address: pslverr with pready
    // Unmapped read returns zero
    // Misaligned address is unmapped
    // Read-only writes dropped silently
    // Unforced advertised write dropped
    //
    // Read side effects
    // Status read reloads since-read flags
    // Event in the read cycle stays set
    // Comma read clears its sticky flags
    // Event in that cycle keeps them set
    // Comma read parks detect at one
    // Next cycle detect follows the line
    // Read value taken before side effects
    // No clear write needed for flags
    //
    // Live fields
    // Status bits 9:0 taken at read cycle
    // Nonzero remote fault means fault
    // Abilities: asym, sym, full, half
    // Comma position and sync likewise live
    // Sync bit low on every other port
    // Comma position void on QSGMII
    //
    // Packet counter
    // Select 00 media lane, 01 MAC lane
    // Select 10 and 11 count nothing
    // One pulse per good packet
    // Counts only while media link up
    // Wraps from top value to zero
    // Active bit is registered link level
    // New select acts from next cycle
    //
    // Advertised word
    // Force bit picks the stored word
    // Otherwise the internal word
    // Output lags selection by one cycle
    // Register clears to zero on reset
    // Stored word read back regardless
    // Software ignores it when unforced
    //
    // Partner word
    // Taken on its valid pulse
    // Held between pulses, read-only
    // Zero after reset
    //
    // Reset
    // Synchronous, active high
    // All flops to reset values
    // Bus outputs low while held
    // Counter and select cleared
    // First setup right after release
    //
    // Hazards
    // Set and clear together: set wins
    // Status read and event: event kept
    // Comma read and realign: flag kept
    // Wrap and count share one update
    // No path from inputs to output pins
    //
    // Limitations
    // No interrupt; software polls flags
    // Pending flags lost on reset
    // Reserved status bits read zero
    // Reserved comma bits read zero
    // Counter bit 14 reads zero
    // Control word is a plain store
    // Only control bit 11 acts here
    // Spare control bits have no effect
    // Select word low bits read zero
    // Detect parked at one only briefly
    // Status bits 12 and 11 also reload

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0] control;
    logic [15:0] adv_word;
    logic [15:0] partner_word;
    // Since-read status flags
    logic        sync_lost_flag;
    logic        cg_bad_flag;
    logic        align_flag;
    logic        restart_flag;
    // Sticky comma flags and parked comma detect
    logic        realign_flag;
    logic        sig_det_flag;
    logic        comma_flag;
    // Packet counter
    logic [1:0]  tx_select;
    logic [13:0] tx_count;
    logic        cnt_active;
    // Bus answer and advertised output
    logic [31:0] read_data;
    logic        ready_q;
    logic        err_q;
    logic [15:0] adv_q;

    // Next values
    logic [15:0] next_control;
    logic [15:0] next_adv_word;
    logic [15:0] next_partner_word;
    logic        next_sync_lost_flag;
    logic        next_cg_bad_flag;
    logic        next_align_flag;
    logic        next_restart_flag;
    logic        next_realign_flag;
    logic        next_sig_det_flag;
    logic        next_comma_flag;
    logic [1:0]  next_tx_select;
    logic [13:0] next_tx_count;
    logic        next_cnt_active;
    logic [31:0] next_read_data;
    logic        next_ready_q;
    logic        next_err_q;
    logic [15:0] next_adv_q;

    // Decode and read views
    logic        access;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic        rd_status;
    logic        rd_comma;
    logic        tx_event;
    logic [15:0] status_word;
    logic [15:0] comma_word;
    logic [15:0] tx_word;
    logic [15:0] wdata16;
    logic [15:0] wmask;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: access phase with one wait state
    assign access    = psel && penable && !ready_q;
    assign wr        = access && pwrite;
    assign rd        = access && !pwrite;
    assign mapped    = (paddr == ADDR_PCS_CONTROL) || (paddr == ADDR_PCS_STATUS)
                    || (paddr == ADDR_ADV_WORD) || (paddr == ADDR_PARTNER_WORD)
                    || (paddr == ADDR_COMMA_STATUS) || (paddr == ADDR_TX_GOOD)
                    || (paddr == ADDR_TX_SELECT);
    assign rd_status = rd && (paddr == ADDR_PCS_STATUS);
    assign rd_comma  = rd && (paddr == ADDR_COMMA_STATUS);
    assign wdata16   = pwdata[15:0];
    assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Packet event from the selected SerDes, gated by media link
    always_comb begin
        case (tx_select)
            SEL_MEDIA: tx_event = tx_in.media_tx_good;  // [RULE_20]
            SEL_MAC:   tx_event = tx_in.mac_tx_good;    // [RULE_20]
            default:   tx_event = 1'b0;
        endcase
        tx_event = tx_event && tx_in.media_link_up;      // [RULE_21]
    end

    // Read views of the status registers
    always_comb begin
        status_word = {sync_lost_flag, cg_bad_flag, 1'b0, align_flag,      // [RULE_01] [RULE_02] [RULE_03]
                       restart_flag, 1'b0, pcs_in.remote_fault,            // [RULE_04] [RULE_05]
                       pcs_in.lp_abilities, pcs_in.lp_an_capable,          // [RULE_06] [RULE_07]
                       pcs_in.link_up, pcs_in.an_complete, pcs_in.signal_detect}; // [RULE_08]
        comma_word  = {realign_flag, sig_det_flag,                         // [RULE_12] [RULE_13]
                       rx_in.qsgmii_sync && FIRST_PORT, comma_flag,        // [RULE_14] [RULE_15]
                       rx_in.comma_pos, 8'h00};                            // [RULE_16]
        tx_word     = {cnt_active, 1'b0, tx_count};                        // [RULE_17]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for all registers
    always_comb begin
        next_control        = control;
        next_adv_word       = adv_word;
        next_partner_word   = partner_word;
        next_tx_select      = tx_select;
        next_tx_count       = tx_count;
        next_cnt_active     = tx_in.media_link_up;                         // [RULE_17]
        next_read_data      = read_data;
        next_ready_q        = access;
        next_err_q          = access && !mapped;
        next_adv_q          = control[BIT_FORCE_ADV] ? adv_word : internal_adv_word; // [RULE_19]
        // Since-read flags: read reloads live value, event set wins
        next_sync_lost_flag = rd_status ? pcs_in.sync_lost : (sync_lost_flag | pcs_in.sync_lost); // [RULE_01] [RULE_22]
        next_cg_bad_flag    = rd_status ? pcs_in.cg_bad : (cg_bad_flag | pcs_in.cg_bad);         // [RULE_02] [RULE_22]
        next_align_flag     = rd_status ? pcs_in.align_err : (align_flag | pcs_in.align_err);    // [RULE_03] [RULE_22]
        next_restart_flag   = rd_status ? pcs_in.lp_restart : (restart_flag | pcs_in.lp_restart); // [RULE_04] [RULE_22]
        next_realign_flag   = rx_in.comma_realign | (realign_flag & !rd_comma);  // [RULE_12]
        next_sig_det_flag   = rx_in.serdes_sig_det | (sig_det_flag & !rd_comma); // [RULE_13]
        // Comma detect follows the line, forced to one by a read
        next_comma_flag     = rd_comma ? 1'b1 : rx_in.comma_detect;             // [RULE_15]
        if (rx_in.partner_word_valid) begin
            next_partner_word = rx_in.partner_word;                              // [RULE_11]
        end
        if (tx_event) begin
            next_tx_count = (tx_count == TX_COUNT_WRAP) ? 14'h0000 : tx_count + 14'h0001; // [RULE_18]
        end
        if (wr) begin
            case (paddr)
                ADDR_PCS_CONTROL: next_control = (control & ~wmask) | (wdata16 & wmask);
                ADDR_ADV_WORD: begin
                    if (control[BIT_FORCE_ADV]) begin                                // [RULE_09]
                        next_adv_word = (adv_word & ~wmask) | (wdata16 & wmask);
                    end
                end
                ADDR_TX_SELECT: begin
                    if (pstrb[1]) begin
                        next_tx_select = pwdata[SEL_LSB+1:SEL_LSB];
                    end
                end
                default: next_control = control;
            endcase
        end
        if (rd) begin
            case (paddr)
                ADDR_PCS_CONTROL:  next_read_data = {16'h0000, control};
                ADDR_PCS_STATUS:   next_read_data = {16'h0000, status_word};
                ADDR_ADV_WORD:     next_read_data = {16'h0000, adv_word};    // [RULE_10]
                ADDR_PARTNER_WORD: next_read_data = {16'h0000, partner_word};
                ADDR_COMMA_STATUS: next_read_data = {16'h0000, comma_word};
                ADDR_TX_GOOD:      next_read_data = {16'h0000, tx_word};
                ADDR_TX_SELECT:    next_read_data = {16'h0000, tx_select, 14'h0000};
                default:           next_read_data = 32'h00000000;
            endcase
        end
    end

    // Register update
    always_ff @(posedge core_clk) begin
        if (reset) begin
            control        <= RESET_CONTROL;
            adv_word       <= RESET_ADV_WORD;                                  // [RULE_09]
            partner_word   <= 16'h0000;
            sync_lost_flag <= 1'b0;
            cg_bad_flag    <= 1'b0;
            align_flag     <= 1'b0;
            restart_flag   <= 1'b0;
            realign_flag   <= 1'b0;
            sig_det_flag   <= 1'b0;
            comma_flag     <= 1'b0;
            tx_select      <= SEL_MEDIA;
            tx_count       <= 14'h0000;
            cnt_active     <= 1'b0;
            read_data      <= 32'h00000000;
            ready_q        <= 1'b0;
            err_q          <= 1'b0;
            adv_q          <= 16'h0000;
        end else begin
            control        <= next_control;
            adv_word       <= next_adv_word;
            partner_word   <= next_partner_word;
            sync_lost_flag <= next_sync_lost_flag;
            cg_bad_flag    <= next_cg_bad_flag;
            align_flag     <= next_align_flag;
            restart_flag   <= next_restart_flag;
            realign_flag   <= next_realign_flag;
            sig_det_flag   <= next_sig_det_flag;
            comma_flag     <= next_comma_flag;
            tx_select      <= next_tx_select;
            tx_count       <= next_tx_count;
            cnt_active     <= next_cnt_active;
            read_data      <= next_read_data;
            ready_q        <= next_ready_q;
            err_q          <= next_err_q;
            adv_q          <= next_adv_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign prdata                       = read_data;
    assign pready                       = ready_q;
    assign pslverr                      = err_q;
    assign adv_word_out                 = adv_q;
    assign force_advertised_ability_bit = control[BIT_FORCE_ADV];

endmodule : mspr_regs
`default_nettype wire

// ### dv/mspr_chk.sv
// Port checker for the PCS status register bank, bound into the design
`timescale 1ns/10ps
`default_nettype none
module mspr_chk
    import mspr_pkg::*;
#(
    parameter bit FIRST_PORT = 1'b1
) (
    input wire logic                  core_clk,
    input wire logic                  reset,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire mspr_pkg::mspr_pcs_type pcs_in,
    input wire mspr_pkg::mspr_rx_type  rx_in,
    input wire logic [15:0]           internal_adv_word,
    input wire logic [15:0]           adv_word_out,
    input wire logic                  force_advertised_ability_bit
);
    import mspr_pkg::*;
    logic rd_at;
    logic mapped;
    logic [15:0] seen_word;
    // Read completion and address decode
    assign rd_at  = pready && !pwrite;
    assign mapped = paddr >= 12'h040 && paddr <= 12'h058 && paddr[1:0] == 2'h0;
    // Last code word offered by the partner
    always_ff @(posedge core_clk) begin
        if (reset) begin
            seen_word <= 16'h0000;
        end else if (rx_in.partner_word_valid) begin
            seen_word <= rx_in.partner_word;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("bad error flag");
    a_sync_sticky: assert property (
        rd_at && paddr == ADDR_PCS_STATUS
        && ($past(pcs_in.sync_lost, 2) || $past(pcs_in.sync_lost, 3) || $past(pcs_in.sync_lost, 4))
        |-> prdata[15]) else $error("sync lost");
    a_cg_sticky: assert property (
        rd_at && paddr == ADDR_PCS_STATUS
        && ($past(pcs_in.cg_bad, 2) || $past(pcs_in.cg_bad, 3) || $past(pcs_in.cg_bad, 4))
        |-> prdata[14]) else $error("code-group");
    a_live_status: assert property (
        rd_at && paddr == ADDR_PCS_STATUS |-> prdata[9:0] == $past(pcs_in[9:0])) else $error("live bits");
    a_partner_held: assert property (
        rd_at && paddr == ADDR_PARTNER_WORD |-> prdata[15:0] == $past(seen_word)) else $error("partner word");
    a_qsgmii_port: assert property (
        rd_at && paddr == ADDR_COMMA_STATUS |-> prdata[13] == (FIRST_PORT && $past(rx_in.qsgmii_sync)))
        else $error("qsgmii bit");
    a_count_range: assert property (
        rd_at && paddr == ADDR_TX_GOOD |-> prdata[13:0] <= TX_COUNT_WRAP && !prdata[14]) else $error("count range");
    a_adv_internal: assert property (
        !$past(reset) && !$past(force_advertised_ability_bit) |-> adv_word_out == $past(internal_adv_word))
        else $error("advertised word");
    // Main scenarios reached
    c_sync_seen: cover property (rd_at && paddr == ADDR_PCS_STATUS && prdata[15]);
    c_count_on: cover property (rd_at && paddr == ADDR_TX_GOOD && prdata[15]);
    c_error: cover property (pslverr);
endmodule : mspr_chk
bind mspr_regs mspr_chk #(.FIRST_PORT(FIRST_PORT)) chk_u (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pcs_in(pcs_in), .rx_in(rx_in), .internal_adv_word(internal_adv_word), .adv_word_out(adv_word_out),
    .force_advertised_ability_bit(force_advertised_ability_bit));
`default_nettype wire

// ### dv/mspr_mac_model.sv
// Behavioural MAC-side partner driving PCS, receiver and transmit events
`timescale 1ns/10ps
`default_nettype none
module mspr_mac_model (
    input  wire logic             core_clk,
    output var mspr_pkg::mspr_pcs_type pcs,
    output var mspr_pkg::mspr_rx_type  rx,
    output var mspr_pkg::mspr_tx_type  tx
);
    import mspr_pkg::*;
    // Quiet link at start
    initial begin
        pcs = '0;
        rx  = '0;
        tx  = '0;
    end
    // One-cycle event levels
    task automatic events(input logic [3:0] ev, input logic [1:0] sd);
        @(posedge core_clk);
        pcs[13:10] <= ev;
        {rx.comma_realign, rx.serdes_sig_det} <= sd;
        @(posedge core_clk);
        pcs[13:10] <= 4'h0;
        {rx.comma_realign, rx.serdes_sig_det} <= 2'h0;
    endtask : events
    // Live levels of PCS and comma logic
    task automatic live(input logic [9:0] st, input logic [5:0] cm);
        @(posedge core_clk);
        pcs[9:0] <= st;
        {rx.qsgmii_sync, rx.comma_detect, rx.comma_pos} <= cm;
    endtask : live
    // One code word, then its inverse so a stale bus never matches
    task automatic word(input logic [15:0] w);
        @(posedge core_clk);
        rx.partner_word_valid <= 1'b1;
        rx.partner_word       <= w;
        @(posedge core_clk);
        rx.partner_word_valid <= 1'b0;
        rx.partner_word       <= ~w;
    endtask : word
    // Good packets on one lane, one every second cycle
    task automatic packets(input int n, input logic mac, input logic up);
        @(posedge core_clk);
        tx.media_link_up <= up;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            tx.mac_tx_good   <= mac;
            tx.media_tx_good <= !mac;
            @(posedge core_clk);
            tx.mac_tx_good   <= 1'b0;
            tx.media_tx_good <= 1'b0;
        end
    endtask : packets
endmodule : mspr_mac_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the PCS status register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mspr_pkg::*;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, force_bit, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic [15:0] iadv, adv_out;
    mspr_pcs_type pcs;
    mspr_rx_type  rx;
    mspr_tx_type  tx;
    int errors, compares;
    mspr_regs dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pcs_in(pcs), .rx_in(rx), .tx_in(tx), .internal_adv_word(iadv), .adv_word_out(adv_out),
        .force_advertised_ability_bit(force_bit));
    mspr_mac_model partner_u (.core_clk(core_clk), .pcs(pcs), .rx(rx), .tx(tx));
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task test_done;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Compare one word
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until ready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    task t_adv;
        rd(ADDR_ADV_WORD, 32'h0);
        apb(1'b1, ADDR_ADV_WORD, 32'h1234);
        rd(ADDR_ADV_WORD, 32'h0);
        apb(1'b1, ADDR_PCS_CONTROL, 32'h0800);
        chk({31'h0, force_bit}, 32'h1);
        apb(1'b1, ADDR_ADV_WORD, 32'hBEEF);
        rd(ADDR_ADV_WORD, 32'hBEEF);
        chk({16'h0, adv_out}, 32'hBEEF);
        pstrb <= 4'h1;
        apb(1'b1, ADDR_ADV_WORD, 32'h1234);
        pstrb <= 4'hF;
        rd(ADDR_ADV_WORD, 32'hBE34);
        apb(1'b1, ADDR_PCS_CONTROL, 32'h0);
        iadv <= 16'h3C5A;
        repeat (2) @(posedge core_clk);
        chk({16'h0, adv_out}, {16'h0, iadv});
        chk({31'h0, force_bit}, 32'h0);
    endtask : t_adv
    task t_status;
        partner_u.live(10'h2AD, 6'h00);
        partner_u.events(4'hF, 2'h0);
        rd(ADDR_PCS_STATUS, 32'hDAAD);
        rd(ADDR_PCS_STATUS, 32'h02AD);
    endtask : t_status
    task t_comma;
        partner_u.live(10'h2AD, 6'h29);
        partner_u.events(4'h0, 2'h3);
        rd(ADDR_COMMA_STATUS, 32'hE900);
        rd(ADDR_COMMA_STATUS, 32'h2900);
        partner_u.live(10'h2AD, 6'h10);
        rd(ADDR_COMMA_STATUS, 32'h1000);
    endtask : t_comma
    task t_word;
        partner_u.word(16'hC3A5);
        rd(ADDR_PARTNER_WORD, 32'hC3A5);
        apb(1'b1, ADDR_PARTNER_WORD, 32'h1111);
        rd(ADDR_PARTNER_WORD, 32'hC3A5);
    endtask : t_word
    task t_count;
        apb(1'b1, ADDR_TX_SELECT, 32'h4000);
        partner_u.packets(2, 1'b1, 1'b0);
        rd(ADDR_TX_GOOD, 32'h0);
        partner_u.packets(3, 1'b1, 1'b1);
        rd(ADDR_TX_GOOD, 32'h8003);
        partner_u.packets(2, 1'b0, 1'b1);
        rd(ADDR_TX_GOOD, 32'h8003);
        apb(1'b1, ADDR_TX_SELECT, 32'h0);
        partner_u.packets(1, 1'b0, 1'b1);
        rd(ADDR_TX_GOOD, 32'h8004);
        partner_u.packets(9996, 1'b0, 1'b1);
        rd(ADDR_TX_GOOD, 32'h8000);
        apb(1'b1, ADDR_TX_SELECT, 32'h8000);
        partner_u.packets(2, 1'b0, 1'b1);
        partner_u.packets(2, 1'b1, 1'b1);
        rd(ADDR_TX_GOOD, 32'h8000);
    endtask : t_count
    task t_unmapped;
        rd(12'h07C, 32'h0);
        chk({31'h0, rerr}, 32'h1);
    endtask : t_unmapped
    ////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Reset, then the scenarios
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        iadv = 16'hA5C3;
        reset = 1'b1;
        errors = 0;
        compares = 0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        t_adv;
        t_status;
        t_comma;
        t_word;
        t_count;
        t_unmapped;
        test_done;
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        test_done;
    end
endmodule : testbench
`default_nettype wire
